// [core/mst_scan_tick.sv]
// scan master with node status table and tick timer, ahb-lite slave
//
// Functional notes
// [R01] ranged scan polls one up to configured maximum
// [R02] full detect scan polls one through sixty-three
// [R03] host keeps maximum and node index 1..63
// [R04] halt command stops cyclic polling
// [R05] status bit0 data request, bit2 one error
// [R06] status bit3 set after three errors
// [R07] status bits 4-6 set after seven errors
// [R08] alive reads one responding, zero dead
// [R09] tick rate is bit rate over product
// [R10] host programs both divisors above one
// [R11] zero divisor stops the tick interrupt
// [R12] tick interrupt enabled separately, none when disabled
// [R13] second divider steps on first's terminal count
`timescale 1ns/1ps
`default_nettype none
module mst_scan_tick import mst_pkg::*; #(
	parameter int DIV_W    = 16,
	parameter int TMO_CYC  = POLL_TMO_CYC
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	input  wire logic             bit_tick,
	output logic                  poll_req,
	output logic [IDX_W-1:0]      poll_idx,
	input  wire logic             poll_ok,
	input  wire logic             poll_err,
	input  wire logic             poll_dreq,
	output logic                  scan_active,
	output logic                  irq
);

	initial begin
		if (DIV_W < 2 || DIV_W > 32)
			$error("mst_scan_tick: DIV_W must be 2..32");
		if (TMO_CYC < 1 || TMO_CYC > 65535)
			$error("mst_scan_tick: TMO_CYC must be 1..65535");
	end

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic             wr_pend_r, wr_pend_nxt;
	logic [7:0]       wr_addr_r, wr_addr_nxt;
	logic [31:0]      rdata_r,   rdata_nxt;
	logic [5:0]       maxidx_r,  maxidx_nxt;
	logic [5:0]       nsel_r,    nsel_nxt;
	logic [DIV_W-1:0] div1_r,    div1_nxt;
	logic [DIV_W-1:0] div2_r,    div2_nxt;
	logic [IRQ_W-1:0] isr_r,     isr_nxt;
	logic [IRQ_W-1:0] ien_r,     ien_nxt;
	logic [IRQ_W-1:0] iset;
	logic [IRQ_W-1:0] iclr;
	mst_state_t       state_r,   state_nxt;
	logic [5:0]       idx_r,     idx_nxt;
	logic             full_r,    full_nxt;
	logic [15:0]      tmo_r,     tmo_nxt;
	logic             req_r,     req_nxt;
	logic             addr_ok;
	logic             wr_cmd;
	logic             cmd_range;
	logic             cmd_full;
	logic             cmd_halt;
	logic [5:0]       last_idx;
	logic             answer;
	logic             tmo_hit;
	logic             tab_upd;
	logic             tab_ok;
	logic             tab_clr;
	logic             pass_evt;
	logic             tick_evt;
	logic [7:0]       nsts;
	logic             nalive;

	// ***************************************************************
	// bus slave
	// ***************************************************************
	// zero wait state: write data lands at the data phase edge
	always_comb begin
		addr_ok     = hsel && hready && htrans[1];
		wr_pend_nxt = addr_ok && hwrite;
		wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
		rdata_nxt   = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			if (haddr[7:0] == A_MAXIDX) begin
				rdata_nxt[5:0] = maxidx_r;
			end else if (haddr[7:0] == A_SCAN) begin
				rdata_nxt[SCAN_RUN]      = (state_r != ST_IDLE);
				rdata_nxt[SCAN_FULL]     = full_r;
				rdata_nxt[SCAN_IDX+:6]   = idx_r;
			end else if (haddr[7:0] == A_NSEL) begin
				rdata_nxt[5:0] = nsel_r;
			end else if (haddr[7:0] == A_NSTS) begin
				rdata_nxt[7:0]        = nsts; // [R05]
				rdata_nxt[NSTS_ALIVE] = nalive; // [R08]
			end else if (haddr[7:0] == A_DIV1) begin
				rdata_nxt[DIV_W-1:0] = div1_r;
			end else if (haddr[7:0] == A_DIV2) begin
				rdata_nxt[DIV_W-1:0] = div2_r;
			end else if (haddr[7:0] == A_IRQ_STS) begin
				rdata_nxt[IRQ_W-1:0] = isr_r;
			end else if (haddr[7:0] == A_IRQ_EN) begin
				rdata_nxt[IRQ_W-1:0] = ien_r;
			end else begin
				rdata_nxt = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r   <= 32'h0000_0000;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;

	// ***************************************************************
	// control registers
	// ***************************************************************
	always_comb begin
		wr_cmd     = wr_pend_r && (wr_addr_r == A_CMD);
		cmd_range  = wr_cmd && hwdata[CMD_RANGE];
		cmd_full   = wr_cmd && hwdata[CMD_FULL];
		cmd_halt   = wr_cmd && hwdata[CMD_HALT];
		maxidx_nxt = maxidx_r;
		nsel_nxt   = nsel_r;
		div1_nxt   = div1_r;
		div2_nxt   = div2_r;
		ien_nxt    = ien_r;
		iclr       = '0;
		if (wr_pend_r) begin
			if (wr_addr_r == A_MAXIDX) begin
				maxidx_nxt = hwdata[5:0]; // [R03]
			end else if (wr_addr_r == A_NSEL) begin
				nsel_nxt = hwdata[5:0]; // [R03]
			end else if (wr_addr_r == A_DIV1) begin
				div1_nxt = hwdata[DIV_W-1:0];
			end else if (wr_addr_r == A_DIV2) begin
				div2_nxt = hwdata[DIV_W-1:0];
			end else if (wr_addr_r == A_IRQ_CLR) begin
				iclr = hwdata[IRQ_W-1:0];
			end else if (wr_addr_r == A_IRQ_EN) begin
				ien_nxt = hwdata[IRQ_W-1:0]; // [R12]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			maxidx_r <= MAXIDX_RST;
			nsel_r   <= NODE_FIRST;
			div1_r   <= '0;
			div2_r   <= '0;
			ien_r    <= IRQ_EN_RST;
		end else begin
			maxidx_r <= maxidx_nxt;
			nsel_r   <= nsel_nxt;
			div1_r   <= div1_nxt;
			div2_r   <= div2_nxt;
			ien_r    <= ien_nxt;
		end
	end

	// ***************************************************************
	// scan sequencer
	// ***************************************************************
	always_comb begin
		last_idx  = full_r ? NODE_LAST : maxidx_r; // [R01] [R02]
		answer    = poll_ok || poll_err;
		tmo_hit   = (tmo_r >= 16'(TMO_CYC - 1));
		state_nxt = state_r;
		idx_nxt   = idx_r;
		full_nxt  = full_r;
		tmo_nxt   = tmo_r;
		req_nxt   = 1'b0;
		tab_upd   = 1'b0;
		tab_ok    = 1'b0;
		tab_clr   = 1'b0;
		pass_evt  = 1'b0;
		// halt beats a start carried in the same write
		if (cmd_halt) begin
			state_nxt = ST_IDLE; // [R04]
		end else if (cmd_range || cmd_full) begin
			full_nxt  = cmd_full; // [R02]
			idx_nxt   = NODE_FIRST; // [R01]
			tab_clr   = 1'b1;
			req_nxt   = 1'b1;
			state_nxt = ST_ISSUE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					state_nxt = ST_IDLE;
				end
				ST_ISSUE: begin
					tmo_nxt   = 16'h0000;
					state_nxt = ST_WAIT;
				end
				ST_WAIT: begin
					tmo_nxt = tmo_r + 16'h0001;
					if (answer || tmo_hit) begin
						// a late answer after timeout is dropped as an error
						tab_upd   = 1'b1;
						tab_ok    = poll_ok && !poll_err;
						req_nxt   = 1'b1;
						state_nxt = ST_ISSUE;
						// >= guards a host that broke the 1..63 range [R03]
						if (idx_r >= last_idx) begin
							idx_nxt  = NODE_FIRST; // [R01] [R02]
							pass_evt = 1'b1;
						end else begin
							idx_nxt = idx_r + 6'h01;
						end
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			idx_r   <= NODE_FIRST;
			full_r  <= 1'b0;
			tmo_r   <= 16'h0000;
			req_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
			full_r  <= full_nxt;
			tmo_r   <= tmo_nxt;
			req_r   <= req_nxt;
		end
	end

	assign poll_req    = req_r;
	assign poll_idx    = idx_r;
	assign scan_active = (state_r != ST_IDLE);

	// ***************************************************************
	// interrupt status
	// ***************************************************************
	always_comb begin
		iset           = '0;
		iset[IRQ_TICK] = tick_evt;
		iset[IRQ_PASS] = pass_evt;
		iset[IRQ_NERR] = tab_upd && !tab_ok;
		// set beats a clear arriving in the same cycle
		isr_nxt        = (isr_r & ~iclr) | iset;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			isr_r <= '0;
		end else begin
			isr_r <= isr_nxt;
		end
	end

	assign irq = |(isr_r & ien_r); // [R12]

	// ***************************************************************
	// sub blocks
	// ***************************************************************
	mst_node_tab u_tab (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.clr_all  (tab_clr),
		.upd      (tab_upd),
		.upd_idx  (idx_r),
		.upd_ok   (tab_ok),
		.upd_dreq (poll_dreq),
		.rd_idx   (nsel_r),
		.rd_sts   (nsts),
		.rd_alive (nalive)
	);

	mst_tick_div #(
		.DIV_W (DIV_W)
	) u_div (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.bit_tick       (bit_tick),
		.first_divisor  (div1_r),
		.second_divisor (div2_r),
		.tick_evt       (tick_evt)
	);

endmodule
`default_nettype wire

// [core/mst_pkg.sv]
// constants, offsets and types shared by the scan and tick timer block
package mst_pkg;

	// ***************************************************************
	// node indexing
	// ***************************************************************
	localparam int        IDX_W      = 6;
	localparam logic [5:0] NODE_FIRST = 6'h01;
	localparam logic [5:0] NODE_LAST  = 6'h3f;
	localparam int        NODE_CNT   = 64;

	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [7:0] A_CMD     = 8'h00;
	localparam logic [7:0] A_MAXIDX  = 8'h04;
	localparam logic [7:0] A_SCAN    = 8'h08;
	localparam logic [7:0] A_NSEL    = 8'h0c;
	localparam logic [7:0] A_NSTS    = 8'h10;
	localparam logic [7:0] A_DIV1    = 8'h14;
	localparam logic [7:0] A_DIV2    = 8'h18;
	localparam logic [7:0] A_IRQ_STS = 8'h1c;
	localparam logic [7:0] A_IRQ_CLR = 8'h20;
	localparam logic [7:0] A_IRQ_EN  = 8'h24;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CMD_RANGE  = 0;
	localparam int CMD_FULL   = 1;
	localparam int CMD_HALT   = 2;
	localparam int ST_DREQ    = 0;
	localparam int ST_ONE     = 2;
	localparam int ST_THREE   = 3;
	localparam int ST_SEVEN   = 4;
	localparam int NSTS_ALIVE = 8;
	localparam int SCAN_RUN   = 0;
	localparam int SCAN_FULL  = 1;
	localparam int SCAN_IDX   = 8;
	localparam int IRQ_TICK   = 0;
	localparam int IRQ_PASS   = 1;
	localparam int IRQ_NERR   = 2;
	localparam int IRQ_W      = 3;

	// ***************************************************************
	// error count thresholds
	// ***************************************************************
	localparam logic [2:0] ERR_ONE   = 3'h1;
	localparam logic [2:0] ERR_THREE = 3'h3;
	localparam logic [2:0] ERR_SEVEN = 3'h7;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [5:0]       MAXIDX_RST = 6'h01;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_NS       = 100;
	localparam int POLL_TMO_NS  = 100000;
	localparam int POLL_TMO_CYC = (POLL_TMO_NS / CLK_NS < 1) ? 1 : POLL_TMO_NS / CLK_NS;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b10
	} mst_state_t;

endpackage

// [core/mst_tick_div.sv]
// two cascaded dividers clocked by the link bit tick
`timescale 1ns/1ps
`default_nettype none
module mst_tick_div import mst_pkg::*; #(
	parameter int DIV_W = 16
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             bit_tick,
	input  wire logic [DIV_W-1:0] first_divisor,
	input  wire logic [DIV_W-1:0] second_divisor,
	output logic                  tick_evt
);

	initial begin
		if (DIV_W < 2)
			$error("mst_tick_div: DIV_W must be at least 2");
	end

	logic [DIV_W-1:0] cnt1_r, cnt1_nxt;
	logic [DIV_W-1:0] cnt2_r, cnt2_nxt;
	logic             evt_r,  evt_nxt;
	logic             run;
	logic             tc1;

	// ***************************************************************
	// divider chain
	// ***************************************************************
	always_comb begin
		// a zero divisor parks both counters so a later restart is phase clean
		run      = (first_divisor != '0) && (second_divisor != '0); // [R11]
		tc1      = run && bit_tick && (cnt1_r >= first_divisor - 1'b1); // [R13]
		cnt1_nxt = cnt1_r;
		cnt2_nxt = cnt2_r;
		evt_nxt  = 1'b0;
		if (!run) begin
			cnt1_nxt = '0;
			cnt2_nxt = '0;
		end else if (bit_tick) begin
			cnt1_nxt = tc1 ? '0 : cnt1_r + 1'b1;
			if (tc1) begin
				// divisor of one passes every tick; software is expected to use more [R10]
				if (cnt2_r >= second_divisor - 1'b1) begin
					cnt2_nxt = '0;
					evt_nxt  = 1'b1; // [R09] [R13]
				end else begin
					cnt2_nxt = cnt2_r + 1'b1; // [R13]
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt1_r <= '0;
			cnt2_r <= '0;
			evt_r  <= 1'b0;
		end else begin
			cnt1_r <= cnt1_nxt;
			cnt2_r <= cnt2_nxt;
			evt_r  <= evt_nxt;
		end
	end

	assign tick_evt = evt_r;

endmodule
`default_nettype wire

// [core/mst_node_tab.sv]
// per node error count, data request and alive table
`timescale 1ns/1ps
`default_nettype none
module mst_node_tab import mst_pkg::*; (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             clr_all,
	input  wire logic             upd,
	input  wire logic [IDX_W-1:0] upd_idx,
	input  wire logic             upd_ok,
	input  wire logic             upd_dreq,
	input  wire logic [IDX_W-1:0] rd_idx,
	output logic [7:0]            rd_sts,
	output logic                  rd_alive
);

	logic [2:0] cnt_r   [NODE_CNT];
	logic [2:0] cnt_nxt [NODE_CNT];
	logic [NODE_CNT-1:0] dreq_r, dreq_nxt;
	logic [NODE_CNT-1:0] alive_r, alive_nxt;
	logic [7:0]          sts_r, sts_nxt;
	logic                live_r, live_nxt;
	logic [2:0]          c;

	// ***************************************************************
	// table update
	// ***************************************************************
	always_comb begin
		dreq_nxt  = dreq_r;
		alive_nxt = alive_r;
		for (int i = 0; i < NODE_CNT; i++) begin
			cnt_nxt[i] = clr_all ? 3'h0 : cnt_r[i];
		end
		if (clr_all) begin
			dreq_nxt  = '0;
			alive_nxt = '0;
		end else if (upd) begin
			alive_nxt[upd_idx] = upd_ok; // [R08]
			if (upd_ok) begin
				dreq_nxt[upd_idx] = upd_dreq; // [R05]
			end else if (cnt_r[upd_idx] != ERR_SEVEN) begin
				// saturate so the top flags never fold back to zero
				cnt_nxt[upd_idx] = cnt_r[upd_idx] + 1'b1;
			end
		end
		c                  = cnt_r[rd_idx];
		sts_nxt            = 8'h00;
		sts_nxt[ST_DREQ]   = dreq_r[rd_idx]; // [R05]
		sts_nxt[ST_ONE]    = (c >= ERR_ONE); // [R05]
		sts_nxt[ST_THREE]  = (c >= ERR_THREE); // [R06]
		sts_nxt[ST_SEVEN+:3] = (c == ERR_SEVEN) ? 3'h7 : 3'h0; // [R07]
		live_nxt           = alive_r[rd_idx]; // [R08]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NODE_CNT; i++) begin
				cnt_r[i] <= 3'h0;
			end
			dreq_r  <= '0;
			alive_r <= '0;
			sts_r   <= 8'h00;
			live_r  <= 1'b0;
		end else begin
			for (int i = 0; i < NODE_CNT; i++) begin
				cnt_r[i] <= cnt_nxt[i];
			end
			dreq_r  <= dreq_nxt;
			alive_r <= alive_nxt;
			sts_r   <= sts_nxt;
			live_r  <= live_nxt;
		end
	end

	assign rd_sts   = sts_r;
	assign rd_alive = live_r;

endmodule
`default_nettype wire

// [tb/mst_scan_tick_chk.sv]
// port level assertions for the scan and tick timer block
`timescale 1ns/1ps
`default_nettype none
module mst_scan_tick_chk import mst_pkg::*; #(
	parameter int TMO_CYC = POLL_TMO_CYC
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        bit_tick,
	input wire logic        poll_req,
	input wire logic [5:0]  poll_idx,
	input wire logic        scan_active,
	input wire logic        irq
);
	// ***************************************************************
	// shadow of the host writes
	// ***************************************************************
	// dead node wait plus slack for the answer and reissue cycles
	localparam int WB = TMO_CYC + 4;
	logic        aw_r;
	logic [7:0]  aa_r;
	logic        full_r;
	logic [5:0]  mx_r;
	logic [2:0]  en_r;
	logic [15:0] d1_r;
	logic [15:0] d2_r;
	wire         cmd = aw_r && aa_r == A_CMD;
	wire         z   = d1_r == 16'h0 || d2_r == 16'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw_r <= 1'b0;
			aa_r <= 8'h0;
			full_r <= 1'b0;
			mx_r <= MAXIDX_RST;
			en_r <= IRQ_EN_RST;
			d1_r <= 16'h0;
			d2_r <= 16'h0;
		end else begin
			aw_r <= hsel && hready && htrans[1] && hwrite;
			aa_r <= haddr[7:0];
			if (aw_r && aa_r == A_MAXIDX) mx_r <= hwdata[5:0];
			if (aw_r && aa_r == A_IRQ_EN) en_r <= hwdata[2:0];
			if (aw_r && aa_r == A_DIV1) d1_r <= hwdata[15:0];
			if (aw_r && aa_r == A_DIV2) d2_r <= hwdata[15:0];
			if (cmd && hwdata[1:0] != 2'h0) full_r <= hwdata[CMD_FULL];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_start;
		cmd && hwdata[1:0] != 2'h0 && !hwdata[CMD_HALT]
			|=> scan_active && poll_req && poll_idx == NODE_FIRST;
	endproperty
	a_start: assert property (p_start) else $error("scan start did not poll node one");
	property p_halt;
		cmd && hwdata[CMD_HALT] |=> (!scan_active && !poll_req) [*4];
	endproperty
	a_halt: assert property (p_halt) else $error("polling went on after halt");
	property p_pulse;
		poll_req |=> !poll_req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("poll request longer than a cycle");
	property p_range;
		poll_req && !full_r |-> poll_idx >= NODE_FIRST && poll_idx <= mx_r;
	endproperty
	a_range: assert property (p_range) else $error("ranged scan left its range");
	property p_nonzero;
		poll_req |-> poll_idx != 6'h0;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("node index zero polled");
	property p_bound;
		poll_req |=> ##[0:WB] (poll_req || !scan_active);
	endproperty
	a_bound: assert property (p_bound) else $error("silent node held the scan");
	property p_irq_off;
		en_r == 3'h0 |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
	property p_tick;
		$rose(irq) && en_r == 3'h1 && $stable(en_r) |-> $past(bit_tick) || $past(bit_tick, 2);
	endproperty
	a_tick: assert property (p_tick) else $error("tick interrupt without bit tick");
	property p_zero;
		z && $past(z) && en_r == 3'h1 && !irq |=> !irq;
	endproperty
	a_zero: assert property (p_zero) else $error("tick with a zero divisor");
	c_full: cover property (cmd && hwdata[CMD_FULL]);
	c_last: cover property (poll_req && poll_idx == NODE_LAST);
	c_tick: cover property ($rose(irq));
endmodule
bind mst_scan_tick mst_scan_tick_chk #(.TMO_CYC(TMO_CYC)) u_mst_scan_tick_chk (.*);
`default_nettype wire

// [tb/mst_node_model.sv]
// partner model: remote nodes answering the master's polls
`timescale 1ns/1ps
`default_nettype none
module mst_node_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        poll_req,
	input  wire logic [5:0]  poll_idx,
	input  wire logic [63:0] live_m,
	input  wire logic [63:0] err_m,
	input  wire logic [63:0] dreq_m,
	input  wire logic [3:0]  lat,
	output logic             poll_ok,
	output logic             poll_err,
	output logic             poll_dreq
);
	// ***************************************************************
	// answer after lat plus one idle cycles; a dead node never answers
	// ***************************************************************
	logic [4:0] cnt_r;
	logic [5:0] idx_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 5'h0;
			idx_r <= 6'h0;
			poll_ok <= 1'b0;
			poll_err <= 1'b0;
			poll_dreq <= 1'b0;
		end else begin
			poll_ok <= 1'b0;
			poll_err <= 1'b0;
			// outside an answer the flag carries no meaning, so it toggles
			poll_dreq <= ~poll_dreq;
			if (cnt_r != 5'h0) cnt_r <= cnt_r - 5'h1;
			if (cnt_r == 5'h1) begin
				poll_ok <= live_m[idx_r] && !err_m[idx_r];
				poll_err <= live_m[idx_r] && err_m[idx_r];
				poll_dreq <= dreq_m[idx_r];
			end
			if (poll_req) begin
				cnt_r <= {1'b0, lat} + 5'h1;
				idx_r <= poll_idx;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_mst_scan_tick.sv]
// self-checking bench for the scan and tick timer block
`timescale 1ns/1ps
`default_nettype none
module tb_mst_scan_tick import mst_pkg::*; ;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [63:0] live_m = 64'h0;
	logic [63:0] err_m = 64'h0;
	logic [63:0] dreq_m = 64'h0;
	logic [3:0]  lat = 4'h0;
	logic        bit_tick = 1'b0;
	logic [1:0]  bt_c = 2'h0;
	wire logic   hready;
	wire logic   hreadyout, hresp, poll_req, poll_ok, poll_err, poll_dreq, scan_active, irq;
	wire logic [31:0] hrdata;
	wire logic [5:0]  poll_idx;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_bt = 0;
	int          n1 = 0;
	int          last = 1;
	int          lim = 1;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	mst_scan_tick #(.TMO_CYC(8)) u_mst_scan_tick (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .bit_tick(bit_tick), .poll_req(poll_req), .poll_idx(poll_idx),
		.poll_ok(poll_ok), .poll_err(poll_err), .poll_dreq(poll_dreq),
		.scan_active(scan_active), .irq(irq));
	mst_node_model u_mst_node_model (.hclk(hclk), .hresetn(hresetn), .poll_req(poll_req),
		.poll_idx(poll_idx), .live_m(live_m), .err_m(err_m), .dreq_m(dreq_m), .lat(lat),
		.poll_ok(poll_ok), .poll_err(poll_err), .poll_dreq(poll_dreq));
	// ***************************************************************
	// link bit tick, poll order monitor, shared tasks
	// ***************************************************************
	always @(posedge hclk) begin
		bt_c <= bt_c + 2'h1;
		bit_tick <= bt_c == 2'h3;
		if (bit_tick) n_bt <= n_bt + 1;
		if (poll_req) begin
			chk("poll_idx", 32'((last >= lim) ? 1 : last + 1), {26'h0, poll_idx});
			last <= int'(poll_idx);
			if (poll_idx == NODE_FIRST) n1 <= n1 + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tmo(input int i);
		if (i >= 20000) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic rdy;
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		if (i >= 50) tmo(20000);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic node(input logic [5:0] n, input logic [31:0] e);
		logic [31:0] q;
		wr(A_NSEL, {26'h0, n});
		repeat (2) @(posedge hclk);
		bus(1'b0, A_NSTS, 32'h0, q);
		chk("node status", e, q);
	endtask
	task automatic scan(input logic [31:0] cmd, input int passes);
		int i;
		last = lim;
		n1 = 0;
		wr(A_CMD, cmd);
		for (i = 0; i < 20000 && n1 <= passes; i++) @(negedge hclk);
		tmo(i);
		wr(A_CMD, 32'h4);
		repeat (20) begin
			@(negedge hclk);
			chk("halted", 32'h0, {30'h0, poll_req, scan_active});
		end
	endtask
	task automatic wait_irq(output int b);
		int i;
		// let a clear that lands on this edge settle before looking
		@(negedge hclk);
		for (i = 0; i < 20000 && irq !== 1'b1; i++) @(negedge hclk);
		tmo(i);
		b = n_bt;
	endtask
	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_regs;
		logic [7:0]  ra [8] = '{A_MAXIDX, A_NSEL, A_DIV1, A_DIV2, A_IRQ_EN, A_IRQ_STS, A_SCAN, 8'h3c};
		logic [31:0] rv [8] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0};
		logic [31:0] q;
		wr(8'h3c, 32'hffff_ffff);
		wr(A_IRQ_STS, 32'hffff_ffff);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0, q);
			chk("reset value", rv[i], q);
		end
		wr(A_DIV2, 32'hffff_ffff);
		bus(1'b0, A_DIV2, 32'h0, q);
		chk("divisor width", 32'hffff, q);
		wr(A_DIV2, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_range;
		int          np [4] = '{1, 3, 7, 8};
		logic [31:0] ex [4] = '{32'h04, 32'h0c, 32'h7c, 32'h7c};
		logic [31:0] q;
		live_m = 64'ha;
		err_m = 64'h8;
		dreq_m = 64'h2;
		lim = 1;
		scan(32'h1, 2);
		wr(A_MAXIDX, 32'h3);
		lim = 3;
		foreach (np[k]) begin
			scan(32'h1, np[k]);
			node(6'h1, 32'h101);
			node(6'h2, ex[k]);
			node(6'h3, ex[k]);
		end
		bus(1'b0, A_IRQ_STS, 32'h0, q);
		chk("error status", 32'h6, q & 32'h7);
		$display("test range done");
	endtask
	task automatic t_full;
		logic [31:0] q;
		live_m = 64'hffff_ffff_ffff_fffe;
		err_m = 64'h0;
		dreq_m = 64'h8000_0000_0000_0000;
		lat = 4'h5;
		wr(A_IRQ_CLR, 32'h7);
		lim = 63;
		scan(32'h2, 1);
		node(6'h3f, 32'h101);
		node(6'h2, 32'h100);
		bus(1'b0, A_IRQ_STS, 32'h0, q);
		chk("pass status", 32'h2, q & 32'h7);
		$display("test full done");
	endtask
	task automatic t_tick;
		int          b0;
		int          b1;
		logic        seen;
		logic [31:0] q;
		wr(A_DIV1, 32'h3);
		wr(A_DIV2, 32'h2);
		wr(A_IRQ_CLR, 32'h7);
		wr(A_IRQ_EN, 32'h1);
		wait_irq(b0);
		wr(A_IRQ_CLR, 32'h1);
		wait_irq(b1);
		chk("bit ticks per irq", 32'h6, 32'(b1 - b0));
		wr(A_IRQ_EN, 32'h0);
		wr(A_IRQ_CLR, 32'h1);
		seen = 1'b0;
		repeat (60) begin
			@(negedge hclk);
			seen |= irq;
		end
		chk("irq while off", 32'h0, {31'h0, seen});
		bus(1'b0, A_IRQ_STS, 32'h0, q);
		chk("tick status", 32'h1, q & 32'h1);
		wr(A_DIV1, 32'h0);
		wr(A_IRQ_CLR, 32'h1);
		wr(A_IRQ_EN, 32'h1);
		repeat (60) begin
			@(negedge hclk);
			seen |= irq;
		end
		bus(1'b0, A_IRQ_STS, 32'h0, q);
		chk("zero divisor", 32'h0, {31'h0, seen} | (q & 32'h1));
		$display("test tick done");
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_range();
		t_full();
		t_tick();
		complete_run();
	end
endmodule
`default_nettype wire
